// >>> verilog/otp_word_pkg.sv
// Register map, field layout and mode codes of the OTP word access slice
package otp_word_pkg;
  localparam logic [31:0] ADDR_DMA_BASE   = 32'h07f4000c;
  localparam logic [31:0] ADDR_CELL       = 32'h07f40010;
  localparam logic [31:0] ADDR_NWORDS     = 32'h07f40014;
  localparam logic [31:0] ADDR_FIFO_PORT  = 32'h07f40018;
  localparam logic [31:0] ADDR_FIFO_LAST  = 32'h07f4001c;
  localparam logic [31:0] ADDR_PWORD_LOW  = 32'h07f40020;
  localparam logic [31:0] ADDR_PWORD_HIGH = 32'h07f40024;
  localparam logic [31:0] ADDR_CONTROL    = 32'h07f40030;
  localparam logic [31:0] ADDR_STATUS     = 32'h07f40034;
  localparam int          FIELD_W         = 14;
  localparam int          FIFO_AW         = 3;
  localparam logic [31:0] RST_ZERO        = 32'h00000000;
  localparam logic [29:0] RST_DMA_BASE    = 30'h07fc0000;
  localparam logic [3:0]  PROG_CYCLES     = 4'h8;
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_DMA_BIT    = 4;
  localparam int          CTRL_MIRROR_BIT = 5;
  localparam int          CTRL_GO_BIT     = 8;
  typedef enum logic [2:0] {
    MODE_STANDBY   = 3'h0,
    MODE_MAN_READ  = 3'h1,
    MODE_MAN_PROG  = 3'h2,
    MODE_AUTO_READ = 3'h3,
    MODE_AUTO_PROG = 3'h4
  } mode_t;
endpackage : otp_word_pkg

// >>> verilog/otp_word_fifo.sv
// Small synchronous FIFO between the port register and the OTP engine
`timescale 1ns/1ns
module otp_word_fifo #(
  parameter int WIDTH = 32,
  parameter int AW    = 3
) (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] pop_data_o,
  output logic      [AW:0]      level_o
);
  logic [WIDTH-1:0] mem_reg [2**AW];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic             do_push;
  logic             do_pop;

  // Overflow and underflow are dropped rather than corrupting state
  assign do_push    = push_i && (level_o != (AW+1)'(2**AW));
  assign do_pop     = pop_i && (level_o != '0);
  assign pop_data_o = mem_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= push_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_o    <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        level_o <= level_o + 1'b1;
      end else if (do_pop && !do_push) begin
        level_o <= level_o - 1'b1;
      end
    end
  end
endmodule : otp_word_fifo

// >>> verilog/otp_word_prog.sv
// Word programming sequencer: holds the 64-bit word and times the pulse
`timescale 1ns/1ns
module otp_word_prog (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        start_i,
  input  wire logic [63:0] word_i,
  input  wire logic [13:0] phys_addr_i,
  output logic             idle_o,
  output logic             otp_prog_o,
  output logic [13:0]      otp_addr_o,
  output logic [63:0]      otp_data_o
);
  logic [3:0] count_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      count_reg  <= 4'h0;
      idle_o     <= 1'b1;
      otp_prog_o <= 1'b0;
      otp_addr_o <= 14'h0000;
      otp_data_o <= 64'h0;
    end else if (idle_o && start_i) begin
      count_reg  <= otp_word_pkg::PROG_CYCLES;
      idle_o     <= 1'b0;
      otp_prog_o <= 1'b1;
      otp_addr_o <= phys_addr_i;
      otp_data_o <= word_i;
    end else if (!idle_o) begin
      count_reg <= count_reg - 4'h1;
      if (count_reg == 4'h1) begin
        idle_o     <= 1'b1;
        otp_prog_o <= 1'b0;
      end
    end
  end

  a_idle_after_start: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    (idle_o && start_i) |=> !idle_o [*8] ##1 idle_o)
    else $error("program idle flag timing wrong");
endmodule : otp_word_prog

// >>> verilog/otp_word_access_regs.sv
// Register slice of the OTP controller: address, count, FIFO, program word
//
// How it works
// - Cell address bits 13:0 count 32-bit application words.
// - Physical word is 72 bits: 8 ECC bits hidden, 64 data bits.
// - Address bit 0 picks the upper half; upper bits pick physical word.
// - Cell address is the start point only in auto read/program modes.
// - Word count holds number of 32-bit words minus one.
// - Internal logic never changes the word count during auto modes.
// - While mirroring, word count shows amount copied so far.
// - Auto program without DMA: each port write pushes the FIFO.
// - Auto read without DMA: each port read pops the FIFO.
// - Each port read captures the popped word in a read-only register.
// - Manual program takes low 32 bits from the low program word.
// - Manual program takes high 32 bits from the high program word.
// - DMA base address is word aligned, bits 1:0 read zero.
// - Program idle flag is zero while programming, one when idle.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module otp_word_access_regs (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [31:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        engine_push_i,
  input  wire logic [31:0] engine_data_i,
  input  wire logic        engine_pop_i,
  input  wire logic        mirror_step_i,
  output logic      [31:0] engine_data_o,
  output logic      [3:0]  fifo_level_status_o,
  output logic      [13:0] start_cell_o,
  output logic             start_upper_o,
  output logic      [13:0] transfer_count_o,
  output logic      [31:0] dma_master_base_o,
  output logic             otp_prog_o,
  output logic      [13:0] otp_addr_o,
  output logic      [71:0] otp_data_o
);
  localparam int FW = otp_word_pkg::FIELD_W;

  logic [FW-1:0]  cell_word_address_reg;
  logic [FW-1:0]  transfer_word_count_reg;
  logic [FW-1:0]  mirror_count_reg;
  logic [31:0]    fifo_last_read_word_reg;
  logic [31:0]    program_word_low_reg;
  logic [31:0]    program_word_high_reg;
  logic [29:0]    dma_master_base_reg;
  logic [2:0]     mode_reg;
  logic           dma_enable_reg;
  logic           mirror_reg;
  logic           prog_start_reg;
  logic           ack_reg;
  logic           wr_hit;
  logic           rd_hit;
  logic           port_push;
  logic           port_pop;
  logic [31:0]    fifo_head;
  logic [3:0]     fifo_level;
  logic           prog_idle;
  logic [63:0]    prog_data;
  logic [31:0]    read_mux;

  // Extend a 14-bit field to a bus word, reserved bits zero
  function automatic logic [31:0] field_word(input logic [FW-1:0] f);
    field_word = {18'h00000, f};
  endfunction : field_word

  // Every access answers one cycle later: waitrequest drops for one edge
  assign wr_hit = avs_write_i && !ack_reg;
  assign rd_hit = avs_read_i && !ack_reg;

  assign port_push = wr_hit && avs_address_i == otp_word_pkg::ADDR_FIFO_PORT
    && mode_reg == otp_word_pkg::MODE_AUTO_PROG && !dma_enable_reg;
  assign port_pop = rd_hit && avs_address_i == otp_word_pkg::ADDR_FIFO_PORT
    && mode_reg == otp_word_pkg::MODE_AUTO_READ && !dma_enable_reg;

  otp_word_fifo #(
    .WIDTH (32),
    .AW    (otp_word_pkg::FIFO_AW)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .push_i      (port_push || engine_push_i),
    .push_data_i (port_push ? avs_writedata_i : engine_data_i),
    .pop_i       (port_pop || engine_pop_i),
    .pop_data_o  (fifo_head),
    .level_o     (fifo_level)
  );

  // Both halves form the 64 application bits; ECC byte driven as zero below
  assign prog_data = {program_word_high_reg, program_word_low_reg};

  otp_word_prog u_prog (
    .sys_clk_i   (sys_clk_i),
    .resetn_i    (resetn_i),
    .start_i     (prog_start_reg),
    .word_i      (prog_data),
    .phys_addr_i ({1'b0, cell_word_address_reg[FW-1:1]}),
    .idle_o      (prog_idle),
    .otp_prog_o  (otp_prog_o),
    .otp_addr_o  (otp_addr_o),
    .otp_data_o  (otp_data_o[63:0])
  );

  // ECC byte is generated by the macro itself and hidden from software
  assign otp_data_o[71:64] = 8'h00;

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ack_reg           <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_reg           <= (avs_read_i || avs_write_i) && !ack_reg;
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_reg);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cell_word_address_reg   <= otp_word_pkg::RST_ZERO[FW-1:0];
      transfer_word_count_reg <= otp_word_pkg::RST_ZERO[FW-1:0];
      program_word_low_reg    <= otp_word_pkg::RST_ZERO;
      program_word_high_reg   <= otp_word_pkg::RST_ZERO;
      dma_master_base_reg     <= otp_word_pkg::RST_DMA_BASE;
      mode_reg                <= otp_word_pkg::MODE_STANDBY;
      dma_enable_reg          <= 1'b0;
      mirror_reg              <= 1'b0;
    end else if (wr_hit) begin
      case (avs_address_i)
        otp_word_pkg::ADDR_CELL: begin
          cell_word_address_reg <= avs_writedata_i[FW-1:0];
        end
        otp_word_pkg::ADDR_NWORDS: begin
          transfer_word_count_reg <= avs_writedata_i[FW-1:0];
        end
        otp_word_pkg::ADDR_PWORD_LOW: begin
          program_word_low_reg <= avs_writedata_i;
        end
        otp_word_pkg::ADDR_PWORD_HIGH: begin
          program_word_high_reg <= avs_writedata_i;
        end
        otp_word_pkg::ADDR_DMA_BASE: begin
          dma_master_base_reg <= avs_writedata_i[31:2];
        end
        otp_word_pkg::ADDR_CONTROL: begin
          mode_reg       <= avs_writedata_i[otp_word_pkg::CTRL_MODE_LSB +: 3];
          dma_enable_reg <= avs_writedata_i[otp_word_pkg::CTRL_DMA_BIT];
          mirror_reg     <= avs_writedata_i[otp_word_pkg::CTRL_MIRROR_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Mirror count clears while mirroring is off and steps on each engine mirror_step_i pulse
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      mirror_count_reg <= '0;
    end else if (!mirror_reg) begin
      mirror_count_reg <= '0;
    end else if (mirror_step_i) begin
      mirror_count_reg <= mirror_count_reg + 1'b1;
    end
  end

  // A go bit is honoured only in manual program mode and while idle
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      prog_start_reg <= 1'b0;
    end else begin
      prog_start_reg <= wr_hit && avs_address_i == otp_word_pkg::ADDR_CONTROL
        && avs_writedata_i[otp_word_pkg::CTRL_GO_BIT]
        && avs_writedata_i[2:0] == otp_word_pkg::MODE_MAN_PROG
        && prog_idle;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      fifo_last_read_word_reg <= otp_word_pkg::RST_ZERO;
    end else if (port_pop) begin
      fifo_last_read_word_reg <= fifo_head;
    end
  end

  always_comb begin
    case (avs_address_i)
      otp_word_pkg::ADDR_CELL:       read_mux = field_word(cell_word_address_reg);
      otp_word_pkg::ADDR_NWORDS:     read_mux = mirror_reg
        ? field_word(mirror_count_reg)
        : field_word(transfer_word_count_reg);
      otp_word_pkg::ADDR_FIFO_PORT:  read_mux = port_pop ? fifo_head : 32'h0;
      otp_word_pkg::ADDR_FIFO_LAST:  read_mux = fifo_last_read_word_reg;
      otp_word_pkg::ADDR_PWORD_LOW:  read_mux = program_word_low_reg;
      otp_word_pkg::ADDR_PWORD_HIGH: read_mux = program_word_high_reg;
      otp_word_pkg::ADDR_DMA_BASE:   read_mux = {dma_master_base_reg, 2'b00};
      otp_word_pkg::ADDR_CONTROL:    read_mux = {26'h0, mirror_reg,
                                                 dma_enable_reg, 1'b0, mode_reg};
      otp_word_pkg::ADDR_STATUS:     read_mux = {27'h0, fifo_level,
                                                 prog_idle};
      default:                       read_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= 32'h0;
    end else if (rd_hit) begin
      avs_readdata_o <= read_mux;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      start_cell_o        <= '0;
      start_upper_o       <= 1'b0;
      transfer_count_o    <= '0;
      dma_master_base_o   <= 32'h0;
      engine_data_o       <= 32'h0;
      fifo_level_status_o <= 4'h0;
    end else begin
      // Start point is only meaningful in the automatic modes
      if (mode_reg == otp_word_pkg::MODE_AUTO_READ ||
          mode_reg == otp_word_pkg::MODE_AUTO_PROG) begin
        start_cell_o  <= {1'b0, cell_word_address_reg[FW-1:1]};
        start_upper_o <= cell_word_address_reg[0];
      end else begin
        start_cell_o  <= '0;
        start_upper_o <= 1'b0;
      end
      transfer_count_o    <= transfer_word_count_reg;
      dma_master_base_o   <= {dma_master_base_reg, 2'b00};
      engine_data_o       <= fifo_head;
      fifo_level_status_o <= fifo_level;
    end
  end

  a_pop_capture: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    port_pop |=> fifo_last_read_word_reg == $past(fifo_head))
    else $error("last read word not captured");

  a_count_hold: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    !(wr_hit && avs_address_i == otp_word_pkg::ADDR_NWORDS)
      |=> $stable(transfer_word_count_reg))
    else $error("word count changed without a write");

  a_reserved_zero: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    ack_reg && ($past(avs_address_i) == otp_word_pkg::ADDR_CELL)
      && $past(avs_read_i) |-> avs_readdata_o[31:14] == 18'h0)
    else $error("reserved address bits not zero");

  a_bus_answer: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer timing wrong");

  a_push_gate: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    port_push && !engine_push_i && !engine_pop_i
      && !fifo_level[otp_word_pkg::FIFO_AW]
      |=> fifo_level == $past(fifo_level) + 4'h1)
    else $error("port write did not push");

  a_pop_level: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    port_pop && !engine_push_i && !engine_pop_i && fifo_level != 4'h0
      |=> fifo_level == $past(fifo_level) - 4'h1)
    else $error("port read did not pop");

  a_prog_word: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    prog_start_reg |=> otp_data_o[31:0] == $past(program_word_low_reg)
      && otp_data_o[63:32] == $past(program_word_high_reg))
    else $error("programmed word mismatch");

  a_dma_align: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    dma_master_base_o[1:0] == 2'b00)
    else $error("dma base not aligned");

  a_start_mode: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    mode_reg != otp_word_pkg::MODE_AUTO_READ
      && mode_reg != otp_word_pkg::MODE_AUTO_PROG
      |=> start_cell_o == 14'h0000 && !start_upper_o)
    else $error("start point shown outside auto modes");

  a_start_cell: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    mode_reg == otp_word_pkg::MODE_AUTO_READ
      |=> start_cell_o == {1'b0, $past(cell_word_address_reg[FW-1:1])}
      && start_upper_o == $past(cell_word_address_reg[0]))
    else $error("start cell split wrong");

  a_prog_addr: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    prog_start_reg
      |=> otp_addr_o == {1'b0, $past(cell_word_address_reg[FW-1:1])})
    else $error("programmed address wrong");

  a_busy_flag: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    otp_prog_o |-> !prog_idle)
    else $error("idle flag high while programming");

  a_data_hold: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    !rd_hit |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");

  a_mirror_read: assert property (@(posedge sys_clk_i)
    disable iff (!resetn_i)
    rd_hit && mirror_reg && avs_address_i == otp_word_pkg::ADDR_NWORDS
      |=> avs_readdata_o[FW-1:0] == $past(mirror_count_reg))
    else $error("mirror count not reported");
endmodule : otp_word_access_regs

// >>> tb/otp_array_model.sv
// Behavioural OTP array and transfer engine facing the register slice
`timescale 1ns/1ns
module otp_array_model (
  input  wire logic        sys_clk_i,
  input  wire logic        otp_prog_i,
  input  wire logic [13:0] otp_addr_i,
  input  wire logic [71:0] otp_data_i,
  output logic             engine_push_o,
  output logic             engine_pop_o,
  output logic             mirror_step_o,
  output logic      [31:0] engine_data_o
);
  logic [71:0] last_word;
  logic [13:0] last_addr;

  initial begin
    engine_push_o = 1'b0;
    engine_pop_o  = 1'b0;
    mirror_step_o = 1'b0;
    engine_data_o = 32'h0;
    last_word     = 72'h0;
  end

  // Array keeps the whole 72-bit word, ECC byte included
  always @(posedge sys_clk_i) begin
    if (otp_prog_i) begin
      last_word <= otp_data_i;
      last_addr <= otp_addr_i;
    end
  end

  // Read fill: one 32-bit word into the FIFO per pulse
  task automatic push_word(input logic [31:0] d);
    @(posedge sys_clk_i);
    engine_push_o <= 1'b1;
    engine_data_o <= d;
    @(posedge sys_clk_i);
    engine_push_o <= 1'b0;
    // Released data must not look like the word just sent
    engine_data_o <= ~d;
  endtask : push_word

  // Program drain: one word leaves the FIFO per pulse
  task automatic pop_word();
    @(posedge sys_clk_i);
    engine_pop_o <= 1'b1;
    @(posedge sys_clk_i);
    engine_pop_o <= 1'b0;
  endtask : pop_word

  task automatic mirror_one();
    @(posedge sys_clk_i);
    mirror_step_o <= 1'b1;
    @(posedge sys_clk_i);
    mirror_step_o <= 1'b0;
  endtask : mirror_one
endmodule : otp_array_model

// >>> tb/otp_word_access_regs_tb.sv
// Self-checking bench for the OTP word access register slice
`timescale 1ns/1ns
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module otp_word_access_regs_tb;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic [31:0] avs_address_i = 32'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        engine_push_i, engine_pop_i, mirror_step_i;
  logic [31:0] engine_data_i, engine_data_o, dma_master_base_o;
  logic [3:0]  fifo_level_status_o;
  logic [13:0] start_cell_o, transfer_count_o, otp_addr_o;
  logic        start_upper_o, otp_prog_o;
  logic [71:0] otp_data_o;
  logic [31:0] r;
  int          failures = 0;
  int          n_tests = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  otp_word_access_regs i_otp_word_access_regs (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .engine_push_i(engine_push_i),
    .engine_data_i(engine_data_i), .engine_pop_i(engine_pop_i),
    .mirror_step_i(mirror_step_i), .engine_data_o(engine_data_o),
    .fifo_level_status_o(fifo_level_status_o), .start_cell_o(start_cell_o),
    .start_upper_o(start_upper_o), .transfer_count_o(transfer_count_o),
    .dma_master_base_o(dma_master_base_o), .otp_prog_o(otp_prog_o),
    .otp_addr_o(otp_addr_o), .otp_data_o(otp_data_o));

  otp_array_model i_otp_array_model (.sys_clk_i(sys_clk_i),
    .otp_prog_i(otp_prog_o), .otp_addr_i(otp_addr_o),
    .otp_data_i(otp_data_o), .engine_push_o(engine_push_i),
    .engine_pop_o(engine_pop_i), .mirror_step_o(mirror_step_i),
    .engine_data_o(engine_data_i));

  // Request held until waitrequest is sampled low, then released
  // Only the watchdog ends a wait that never gets its answer
  task automatic bus_access(input logic is_wr, input logic [31:0] a, d);
    @(posedge sys_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= is_wr;
    avs_read_i      <= ~is_wr;
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus_access

  task automatic wr(input logic [31:0] a, d);
    bus_access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [31:0] a);
    bus_access(1'b0, a, 32'h0);
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic t_reset_values();
    logic [31:0] addrs [6];
    addrs = '{otp_word_pkg::ADDR_CELL, otp_word_pkg::ADDR_NWORDS,
              otp_word_pkg::ADDR_FIFO_PORT, otp_word_pkg::ADDR_FIFO_LAST,
              otp_word_pkg::ADDR_PWORD_LOW, 32'h07f40040};
    foreach (addrs[i]) begin
      rd(addrs[i]);
      `CHK(r, 32'h0)
    end
    rd(otp_word_pkg::ADDR_STATUS);
    `CHK(r[0], 1'b1)
    `CHK(dma_master_base_o, 32'h1ff00000)
  endtask : t_reset_values

  task automatic t_cell();
    wr(otp_word_pkg::ADDR_CELL, 32'hffffffff);
    rd(otp_word_pkg::ADDR_CELL);
    `CHK(r, 32'h00003fff)
    settle();
    `CHK(start_cell_o, 14'h0)
    wr(otp_word_pkg::ADDR_CONTROL, 32'h3);
    settle();
    `CHK(start_cell_o, 14'h1fff)
    `CHK(start_upper_o, 1'b1)
    wr(otp_word_pkg::ADDR_CELL, 32'h6);
    wr(otp_word_pkg::ADDR_CONTROL, 32'h4);
    settle();
    `CHK(start_cell_o, 14'h0003)
    `CHK(start_upper_o, 1'b0)
    wr(otp_word_pkg::ADDR_CONTROL, 32'h0);
  endtask : t_cell

  task automatic t_count();
    wr(otp_word_pkg::ADDR_NWORDS, 32'h00012345);
    rd(otp_word_pkg::ADDR_NWORDS);
    `CHK(r, 32'h00002345)
    `CHK(transfer_count_o, 14'h2345)
    wr(otp_word_pkg::ADDR_CONTROL, 32'h20);
    repeat (3) i_otp_array_model.mirror_one();
    rd(otp_word_pkg::ADDR_NWORDS);
    `CHK(r, 32'h3)
    wr(otp_word_pkg::ADDR_CONTROL, 32'h3);
    rd(otp_word_pkg::ADDR_NWORDS);
    `CHK(r, 32'h00002345)
  endtask : t_count

  task automatic t_fifo_read();
    i_otp_array_model.push_word(32'ha5a50001);
    i_otp_array_model.push_word(32'h5a5a0002);
    settle();
    `CHK(fifo_level_status_o, 4'h2)
    rd(otp_word_pkg::ADDR_STATUS);
    `CHK(r[4:1], 4'h2)
    rd(otp_word_pkg::ADDR_FIFO_PORT);
    `CHK(r, 32'ha5a50001)
    rd(otp_word_pkg::ADDR_FIFO_LAST);
    `CHK(r, 32'ha5a50001)
    // With DMA on the port must not steal a word
    wr(otp_word_pkg::ADDR_CONTROL, 32'h13);
    rd(otp_word_pkg::ADDR_FIFO_PORT);
    `CHK(r, 32'h0)
    wr(otp_word_pkg::ADDR_CONTROL, 32'h3);
    rd(otp_word_pkg::ADDR_FIFO_PORT);
    `CHK(r, 32'h5a5a0002)
    rd(otp_word_pkg::ADDR_FIFO_LAST);
    `CHK(r, 32'h5a5a0002)
    settle();
    `CHK(fifo_level_status_o, 4'h0)
  endtask : t_fifo_read

  task automatic t_fifo_write();
    wr(otp_word_pkg::ADDR_CONTROL, 32'h4);
    rd(otp_word_pkg::ADDR_STATUS);
    `CHK(r[4:1], 4'h0)
    wr(otp_word_pkg::ADDR_FIFO_PORT, 32'hc0de0001);
    wr(otp_word_pkg::ADDR_FIFO_PORT, 32'hc0de0002);
    settle();
    `CHK(fifo_level_status_o, 4'h2)
    `CHK(engine_data_o, 32'hc0de0001)
    i_otp_array_model.pop_word();
    settle();
    `CHK(engine_data_o, 32'hc0de0002)
    i_otp_array_model.pop_word();
    wr(otp_word_pkg::ADDR_CONTROL, 32'h14);
    wr(otp_word_pkg::ADDR_FIFO_PORT, 32'hc0de0003);
    settle();
    `CHK(fifo_level_status_o, 4'h0)
  endtask : t_fifo_write

  task automatic t_manual_prog();
    wr(otp_word_pkg::ADDR_PWORD_LOW, 32'h12345678);
    rd(otp_word_pkg::ADDR_PWORD_LOW);
    `CHK(r, 32'h12345678)
    wr(otp_word_pkg::ADDR_PWORD_HIGH, 32'h9abcdef0);
    wr(otp_word_pkg::ADDR_CONTROL, 32'h102);
    rd(otp_word_pkg::ADDR_STATUS);
    `CHK(r[0], 1'b0)
    // Go bit is write-only and reads back as zero
    rd(otp_word_pkg::ADDR_CONTROL);
    `CHK(r, 32'h2)
    repeat (20) @(posedge sys_clk_i);
    rd(otp_word_pkg::ADDR_STATUS);
    `CHK(r[0], 1'b1)
    `CHK(i_otp_array_model.last_word[71:64], 8'h0)
    `CHK(i_otp_array_model.last_word[63:0], 64'h9abcdef012345678)
    `CHK(i_otp_array_model.last_addr, 14'h0003)
  endtask : t_manual_prog

  task automatic t_dma_base();
    wr(otp_word_pkg::ADDR_DMA_BASE, 32'hffffffff);
    rd(otp_word_pkg::ADDR_DMA_BASE);
    `CHK(r, 32'hfffffffc)
    settle();
    `CHK(dma_master_base_o, 32'hfffffffc)
  endtask : t_dma_base

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_reset_values();
    t_cell();
    t_count();
    t_fifo_read();
    t_fifo_write();
    t_manual_prog();
    t_dma_base();
    complete_run();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule : otp_word_access_regs_tb
